//--- inc/dspsc_defs.svh
`ifndef DSPSC_DEFS_SVH
`define DSPSC_DEFS_SVH

// Register byte addresses.
`define DSPSC_PMEM_PWR_ADDR 24'h017094
`define DSPSC_PMEM_FIRST_ADDR 24'h017098
`define DSPSC_PMEM_LAST_ADDR 24'h0170b0
`define DSPSC_CLK_REQ_ADDR 24'hb80000
`define DSPSC_CLK_ACT_ADDR 24'hb80008
`define DSPSC_SOFT_RST_ADDR 24'hb80010
`define DSPSC_ARB_CTRL_ADDR 24'hb80050
`define DSPSC_CORE_CTRL_ADDR 24'hbc1000
`define DSPSC_ARB_MASK_ADDR 24'hbc5a00

// Field positions.
`define DSPSC_ODD_BIT 0
`define DSPSC_EVEN_BIT 1
`define DSPSC_CORE_EN_BIT 0
`define DSPSC_CORE_RST_BIT 9
`define DSPSC_PULSE_BIT 0

// Sizes and reset values.
`define DSPSC_NUM_BANKS 7
`define DSPSC_NUM_MASTERS 8
`define DSPSC_CLK_REQ_RST 16'h0000
`define DSPSC_ARB_MASK_RST 8'h00

// Clock rates in 1/64 MHz units: source is 20 MHz, DSP ceiling chosen equal.
`define DSPSC_SRC_FREQ 16'h0500
`define DSPSC_MAX_FREQ 16'h0500

`endif

//--- inc/dspsc_pkg.sv
package dspsc_pkg;
  typedef enum logic [1:0] {
    DSPSC_CORE_HELD,
    DSPSC_CORE_RESTART,
    DSPSC_CORE_RUN
  } dspsc_core_state_e;
  typedef logic [15:0] dspsc_freq_t;
endpackage

//--- core/dspsc_clk_div.sv
`timescale 1ns/1ps
`include "dspsc_defs.svh"

// Picks the largest integer divider whose output stays at or above the request, or the smallest legal divider when none does.
module dspsc_clk_div (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire dspsc_pkg::dspsc_freq_t req_i,
  output dspsc_pkg::dspsc_freq_t actual_o,
  output logic tick_o
);
  dspsc_pkg::dspsc_freq_t div;
  dspsc_pkg::dspsc_freq_t limit;
  dspsc_pkg::dspsc_freq_t cnt_ff;
  logic tick_ff;

  // Rounding the divider down keeps the rate at or above the request; the smallest legal divider caps it.
  always_comb begin
    limit = 16'((`DSPSC_SRC_FREQ + `DSPSC_MAX_FREQ - 16'h0001) / `DSPSC_MAX_FREQ);
    if (req_i == 16'h0000) begin
      div = `DSPSC_SRC_FREQ;
    end else begin
      div = 16'(`DSPSC_SRC_FREQ / req_i);
    end
    if (div < limit) begin
      div = limit;
    end
    actual_o = 16'(`DSPSC_SRC_FREQ / div);
  end

  // Divided clock enable runs only while something needs the DSP clock.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end else if (ce_i) begin
      if (!run_i || cnt_ff + 16'h0001 >= div) begin
        cnt_ff <= 16'h0000;
      end else begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
      tick_ff <= run_i && (cnt_ff == 16'h0000);
    end
  end

  assign tick_o = tick_ff;
endmodule

//--- core/dspsc_ctrl.sv
`timescale 1ns/1ps
`include "dspsc_defs.svh"

module dspsc_ctrl (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [23:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] arb_active_i,
  input wire logic [6:0] err_src_i,
  input wire logic [3:0] gp_irq_i,
  input wire logic [1:0] prof_done_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic [6:0] pmem_even_avail_o,
  output logic [6:0] pmem_odd_avail_o,
  output logic pmem_even_active_o,
  output logic pmem_odd_active_o,
  output logic core_reset_n_o,
  output logic core_clk_en_o,
  output logic [7:0] arb_reset_o,
  output logic nmi_cfg_reset_o,
  output logic wdog_reset_o,
  output logic clk_low_event_o,
  output logic [6:0] err_irq_o,
  output logic [3:0] gp_irq_o,
  output logic [1:0] prof_irq_o,
  output logic nmi_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic pmem_even_power_ff;
  logic pmem_odd_power_ff;
  logic [6:0] pmem_even_bank_enable_ff;
  logic [6:0] pmem_odd_bank_enable_ff;
  dspsc_pkg::dspsc_freq_t core_clock_request_ff;
  logic core_run_enable_ff;
  logic [7:0] arbiter_resync_select_ff;
  logic subsystem_reset_pulse_ff;
  logic core_reset_pulse_ff;
  logic arbiter_resync_pulse_ff;
  dspsc_pkg::dspsc_core_state_e core_state_ff;
  dspsc_pkg::dspsc_core_state_e nxt_core_state;
  dspsc_pkg::dspsc_freq_t core_clock_actual;
  logic div_tick;
  logic clk_needed;
  logic wr_soft;
  logic wr_core;
  logic wr_arb;
  logic [2:0] bank_idx;
  logic bank_hit;
  logic [31:0] nxt_rdata;
  logic [6:0] even_chain;
  logic [6:0] odd_chain;
  logic [6:0] err_irq_ff;
  logic [3:0] gp_irq_ff;
  logic [1:0] prof_irq_ff;
  logic nmi_ff;
  logic clk_low_ff;
  logic [6:0] even_avail_ff;
  logic [6:0] odd_avail_ff;
  logic even_active_ff;
  logic odd_active_ff;
  logic core_reset_n_ff;
  logic core_clk_en_ff;
  logic [7:0] arb_reset_ff;
  logic [31:0] rdata_ff;
  logic rvalid_ff;
  logic subsys_reset_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode for the write-one pulse registers and the bank array.
  assign wr_soft = reg_wr_i && (reg_addr_i == `DSPSC_SOFT_RST_ADDR);
  assign wr_core = reg_wr_i && (reg_addr_i == `DSPSC_CORE_CTRL_ADDR);
  assign wr_arb = reg_wr_i && (reg_addr_i == `DSPSC_ARB_CTRL_ADDR);
  assign bank_hit = (reg_addr_i >= `DSPSC_PMEM_FIRST_ADDR) && (reg_addr_i <= `DSPSC_PMEM_LAST_ADDR) &&
                    (reg_addr_i[1:0] == 2'h0);
  assign bank_idx = 3'((reg_addr_i - `DSPSC_PMEM_FIRST_ADDR) >> 2);

  // Memory controls are reset only by the pin reset, never by the soft reset.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pmem_even_power_ff <= 1'b0;
      pmem_odd_power_ff <= 1'b0;
      pmem_even_bank_enable_ff <= 7'h00;
      pmem_odd_bank_enable_ff <= 7'h00;
    end else if (ce_i && reg_wr_i) begin
      if (reg_addr_i == `DSPSC_PMEM_PWR_ADDR) begin
        pmem_even_power_ff <= reg_wdata_i[`DSPSC_EVEN_BIT];
        pmem_odd_power_ff <= reg_wdata_i[`DSPSC_ODD_BIT];
      end
      if (bank_hit) begin
        pmem_even_bank_enable_ff[bank_idx] <= reg_wdata_i[`DSPSC_EVEN_BIT];
        pmem_odd_bank_enable_ff[bank_idx] <= reg_wdata_i[`DSPSC_ODD_BIT];
      end
    end
  end

  // Clock request; cleared by the subsystem soft reset.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_clock_request_ff <= `DSPSC_CLK_REQ_RST;
    end else if (ce_i) begin
      if (wr_soft && reg_wdata_i[`DSPSC_PULSE_BIT]) begin
        core_clock_request_ff <= `DSPSC_CLK_REQ_RST;
      end else if (reg_wr_i && reg_addr_i == `DSPSC_CLK_REQ_ADDR) begin
        core_clock_request_ff <= reg_wdata_i[15:0];
      end
    end
  end

  // Core enable and resync mask.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_run_enable_ff <= 1'b0;
      arbiter_resync_select_ff <= `DSPSC_ARB_MASK_RST;
    end else if (ce_i) begin
      if (wr_core) begin
        core_run_enable_ff <= reg_wdata_i[`DSPSC_CORE_EN_BIT];
      end
      if (reg_wr_i && reg_addr_i == `DSPSC_ARB_MASK_ADDR) begin
        arbiter_resync_select_ff <= reg_wdata_i[7:0];
      end
    end
  end

  // Write-one pulses last a single cycle and never store.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      subsystem_reset_pulse_ff <= 1'b0;
      core_reset_pulse_ff <= 1'b0;
      arbiter_resync_pulse_ff <= 1'b0;
    end else if (ce_i) begin
      subsystem_reset_pulse_ff <= wr_soft && reg_wdata_i[`DSPSC_PULSE_BIT];
      core_reset_pulse_ff <= wr_core && reg_wdata_i[`DSPSC_CORE_RST_BIT];
      arbiter_resync_pulse_ff <= wr_arb && reg_wdata_i[`DSPSC_PULSE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core sequencing: held while disabled, one restart cycle after any reset.
  always_comb begin
    nxt_core_state = core_state_ff;
    case (core_state_ff)
      dspsc_pkg::DSPSC_CORE_HELD: begin
        if (core_run_enable_ff) begin
          nxt_core_state = dspsc_pkg::DSPSC_CORE_RESTART;
        end
      end
      dspsc_pkg::DSPSC_CORE_RESTART: begin
        nxt_core_state = core_run_enable_ff ? dspsc_pkg::DSPSC_CORE_RUN : dspsc_pkg::DSPSC_CORE_HELD;
      end
      dspsc_pkg::DSPSC_CORE_RUN: begin
        if (!core_run_enable_ff) begin
          nxt_core_state = dspsc_pkg::DSPSC_CORE_HELD;
        end else if (core_reset_pulse_ff || subsystem_reset_pulse_ff) begin
          nxt_core_state = dspsc_pkg::DSPSC_CORE_RESTART;
        end
      end
      default: begin
        nxt_core_state = dspsc_pkg::DSPSC_CORE_HELD;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_state_ff <= dspsc_pkg::DSPSC_CORE_HELD;
    end else if (ce_i) begin
      core_state_ff <= nxt_core_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The DSP clock runs only for a running core or an active arbiter master.
  assign clk_needed = (core_state_ff == dspsc_pkg::DSPSC_CORE_RUN) || (|arb_active_i);

  dspsc_clk_div dspsc_clk_div_i (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .run_i(clk_needed),
    .req_i(core_clock_request_ff),
    .actual_o(core_clock_actual),
    .tick_o(div_tick)
  );

  // Bank availability: a disabled bank masks every bank above it.
  always_comb begin
    even_chain[0] = pmem_even_bank_enable_ff[0];
    odd_chain[0] = pmem_odd_bank_enable_ff[0];
    for (int i = 1; i < `DSPSC_NUM_BANKS; i++) begin
      even_chain[i] = even_chain[i-1] && pmem_even_bank_enable_ff[i];
      odd_chain[i] = odd_chain[i-1] && pmem_odd_bank_enable_ff[i];
    end
  end

  // Control outputs toward the core, arbiters, memory and watchdog.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      even_avail_ff <= 7'h00;
      odd_avail_ff <= 7'h00;
      even_active_ff <= 1'b0;
      odd_active_ff <= 1'b0;
      core_reset_n_ff <= 1'b0;
      core_clk_en_ff <= 1'b0;
      arb_reset_ff <= 8'h00;
      subsys_reset_ff <= 1'b0;
    end else if (ce_i) begin
      even_avail_ff <= even_chain;
      odd_avail_ff <= odd_chain;
      even_active_ff <= pmem_even_power_ff && (|even_chain);
      odd_active_ff <= pmem_odd_power_ff && (|odd_chain);
      core_reset_n_ff <= (core_state_ff == dspsc_pkg::DSPSC_CORE_RUN);
      core_clk_en_ff <= div_tick;
      arb_reset_ff <= ({8{arbiter_resync_pulse_ff}} & arbiter_resync_select_ff) |
                      {8{subsystem_reset_pulse_ff}};
      subsys_reset_ff <= subsystem_reset_pulse_ff;
    end
  end

  // Interrupt event lines registered straight through; nmi and clock-low are qualified by the running core.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_irq_ff <= 7'h00;
      gp_irq_ff <= 4'h0;
      prof_irq_ff <= 2'h0;
      nmi_ff <= 1'b0;
      clk_low_ff <= 1'b0;
    end else if (ce_i) begin
      err_irq_ff <= err_src_i;
      gp_irq_ff <= gp_irq_i;
      prof_irq_ff <= prof_done_i;
      nmi_ff <= err_src_i[5] && (core_state_ff == dspsc_pkg::DSPSC_CORE_RUN);
      clk_low_ff <= (core_state_ff == dspsc_pkg::DSPSC_CORE_RUN) &&
                    (core_clock_actual < core_clock_request_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; pulse registers and unmapped addresses read zero.
  always_comb begin
    nxt_rdata = 32'h00000000;
    if (reg_addr_i == `DSPSC_PMEM_PWR_ADDR) begin
      nxt_rdata = {30'h0, pmem_even_power_ff, pmem_odd_power_ff};
    end else if (bank_hit) begin
      nxt_rdata = {30'h0, pmem_even_bank_enable_ff[bank_idx], pmem_odd_bank_enable_ff[bank_idx]};
    end else if (reg_addr_i == `DSPSC_CLK_REQ_ADDR) begin
      nxt_rdata = {16'h0, core_clock_request_ff};
    end else if (reg_addr_i == `DSPSC_CLK_ACT_ADDR) begin
      nxt_rdata = {16'h0, (core_run_enable_ff ? core_clock_actual : 16'h0000)};
    end else if (reg_addr_i == `DSPSC_CORE_CTRL_ADDR) begin
      nxt_rdata = {31'h0, core_run_enable_ff};
    end else if (reg_addr_i == `DSPSC_ARB_MASK_ADDR) begin
      nxt_rdata = {24'h0, arbiter_resync_select_ff};
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= 32'h00000000;
      rvalid_ff <= 1'b0;
    end else if (ce_i) begin
      rvalid_ff <= reg_rd_i;
      if (reg_rd_i) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign reg_rvalid_o = rvalid_ff;
  assign pmem_even_avail_o = even_avail_ff;
  assign pmem_odd_avail_o = odd_avail_ff;
  assign pmem_even_active_o = even_active_ff;
  assign pmem_odd_active_o = odd_active_ff;
  assign core_reset_n_o = core_reset_n_ff;
  assign core_clk_en_o = core_clk_en_ff;
  assign arb_reset_o = arb_reset_ff;
  assign nmi_cfg_reset_o = subsys_reset_ff;
  assign wdog_reset_o = subsys_reset_ff;
  assign clk_low_event_o = clk_low_ff;
  assign err_irq_o = err_irq_ff;
  assign gp_irq_o = gp_irq_ff;
  assign prof_irq_o = prof_irq_ff;
  assign nmi_o = nmi_ff;
endmodule

//--- tb/dspsc_ctrl_monitor.sv
`timescale 1ns/1ps
`include "dspsc_defs.svh"

// Ties the reset pulses, core hold and event copies to their causes at the ports.
module dspsc_ctrl_monitor (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [23:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic [6:0] err_src_i,
  input wire logic [6:0] pmem_even_avail_o,
  input wire logic [6:0] pmem_odd_avail_o,
  input wire logic pmem_odd_active_o,
  input wire logic core_reset_n_o,
  input wire logic [7:0] arb_reset_o,
  input wire logic wdog_reset_o,
  input wire logic nmi_cfg_reset_o,
  input wire logic [6:0] err_irq_o,
  input wire logic nmi_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic arb_wr;
  //////////////////////////////////////////////////////////////////////////////
  // A taken write that may legally start a master reset pulse.
  assign arb_wr = reg_wr_i && ce_i && (reg_addr_i == `DSPSC_ARB_CTRL_ADDR || reg_addr_i == `DSPSC_SOFT_RST_ADDR);
  // Taken writes that start the pulse, restart and hold behaviours.
  sequence wr_set(a, b);
    reg_wr_i && ce_i && reg_addr_i == a && reg_wdata_i[b];
  endsequence
  sequence core_off;
    reg_wr_i && ce_i && reg_addr_i == `DSPSC_CORE_CTRL_ADDR && !reg_wdata_i[0];
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  core_hold_a: assert property (core_off |-> ##[1:3] !core_reset_n_o)
    else $error("core not held in reset after disable");
  core_restart_a: assert property (wr_set(`DSPSC_CORE_CTRL_ADDR, 9) ##0 core_reset_n_o |-> ##[1:4] !core_reset_n_o)
    else $error("core reset write did not restart the core");
  soft_reset_a: assert property (wr_set(`DSPSC_SOFT_RST_ADDR, 0) |->
    ##[2:3] (arb_reset_o == 8'hff && wdog_reset_o && nmi_cfg_reset_o))
    else $error("soft reset did not reach all subsystem parts");
  pulse_once_a: assert property ($rose(wdog_reset_o) |=> !wdog_reset_o && !nmi_cfg_reset_o)
    else $error("reset pulse longer than one cycle");
  arb_cause_a: assert property (arb_reset_o != 8'h00 |-> $past(arb_wr, 2) || $past(arb_wr, 3))
    else $error("master reset without a resync or soft reset write");
  irq_copy_a: assert property ($past(rst_n_i) && $past(ce_i) |-> err_irq_o == $past(err_src_i))
    else $error("error line does not follow its source");
  nmi_path_a: assert property (nmi_o && $past(ce_i) |-> $past(err_src_i[5]))
    else $error("nmi raised without its source");
  bank_chain_a: assert property ((pmem_even_avail_o & ~{pmem_even_avail_o[5:0], 1'b1}) == 7'h00 &&
    (pmem_odd_avail_o & ~{pmem_odd_avail_o[5:0], 1'b1}) == 7'h00)
    else $error("bank available above a disabled bank");
  odd_active_a: assert property (pmem_odd_active_o |-> pmem_odd_avail_o != 7'h00)
    else $error("odd memory active with no bank enabled");
endmodule

bind dspsc_ctrl dspsc_ctrl_monitor dspsc_ctrl_monitor_i (.ref_clk_i, .rst_n_i, .ce_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .err_src_i, .pmem_even_avail_o, .pmem_odd_avail_o, .pmem_odd_active_o, .core_reset_n_o,
  .arb_reset_o, .wdog_reset_o, .nmi_cfg_reset_o, .err_irq_o, .nmi_o);

//--- tb/dspsc_host_model.sv
`timescale 1ns/1ps

// Host side of the register port: each strobe stands for exactly one rising edge.
module dspsc_host_model (
  input wire logic ref_clk_i,
  input wire logic [31:0] rdata_i,
  input wire logic rvalid_i,
  output logic [23:0] addr_o,
  output logic [31:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  // Idle bus at time zero.
  initial begin
    addr_o = 24'h000000;
    wdata_o = 32'h00000000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // Released lines show the inverse of their last value so stale data never looks valid.
  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    @(negedge ref_clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge ref_clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  // Reads one word, waiting a bounded time for the valid pulse.
  task automatic rd(input logic [23:0] a, output logic [31:0] d);
    d = 'x;
    @(negedge ref_clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge ref_clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    for (int n = 0; n < 4; n++) begin
      if (rvalid_i === 1'b1) d = rdata_i;
      @(negedge ref_clk_i);
    end
  endtask
endmodule

//--- tb/tb_dspsc_ctrl.sv
`timescale 1ns/1ps
`include "dspsc_defs.svh"

module tb_dspsc_ctrl;
  logic ref_clk_i, rst_n_i, ce_i, reg_wr_i, reg_rd_i, reg_rvalid_o, nmi_o, clk_low_event_o;
  logic [23:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, rv;
  logic [7:0] arb_active_i, arb_reset_o;
  logic [6:0] err_src_i, err_irq_o, pmem_even_avail_o, pmem_odd_avail_o;
  logic [3:0] gp_irq_i, gp_irq_o;
  logic [1:0] prof_done_i, prof_irq_o;
  logic pmem_even_active_o, pmem_odd_active_o, core_reset_n_o, core_clk_en_o, nmi_cfg_reset_o, wdog_reset_o;
  logic [9:0] pv;
  int n_errors, cmp_count, cyc, k;
  logic [23:0] addrs [10] = '{`DSPSC_CLK_REQ_ADDR, `DSPSC_CLK_ACT_ADDR, `DSPSC_SOFT_RST_ADDR, `DSPSC_ARB_CTRL_ADDR,
    `DSPSC_CORE_CTRL_ADDR, `DSPSC_ARB_MASK_ADDR, `DSPSC_PMEM_PWR_ADDR, `DSPSC_PMEM_FIRST_ADDR,
    `DSPSC_PMEM_LAST_ADDR, 24'h000004};
  int reqs [3] = '{16'h0200, 16'h0500, 16'h0190};

  dspsc_ctrl dspsc_ctrl_i (.ref_clk_i, .rst_n_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .arb_active_i, .err_src_i, .gp_irq_i, .prof_done_i, .reg_rdata_o, .reg_rvalid_o, .pmem_even_avail_o,
    .pmem_odd_avail_o, .pmem_even_active_o, .pmem_odd_active_o, .core_reset_n_o, .core_clk_en_o, .arb_reset_o,
    .nmi_cfg_reset_o, .wdog_reset_o, .clk_low_event_o, .err_irq_o, .gp_irq_o, .prof_irq_o, .nmi_o);
  dspsc_host_model dspsc_host_model_i (.ref_clk_i, .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o),
    .addr_o(reg_addr_i), .wdata_o(reg_wdata_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i));
  //////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Reads a register and compares it.
  task automatic rchk(input string nm, input logic [23:0] a, input logic [31:0] e);
    dspsc_host_model_i.rd(a, rv);
    chk(nm, e, rv);
  endtask
  // Gathers the reset pulses seen over a few cycles.
  task automatic cap;
    pv = 10'h000;
    repeat (5) begin
      @(negedge ref_clk_i);
      pv = pv | {nmi_cfg_reset_o, wdog_reset_o, arb_reset_o};
    end
  endtask
  // Expected actual rate for a request, and a count of DSP clock enable pulses over twenty cycles.
  function automatic int fexp(input int r);
    return `DSPSC_SRC_FREQ / (`DSPSC_SRC_FREQ / r);
  endfunction
  task automatic cnt(output int c);
    c = 0;
    repeat (20) begin
      @(negedge ref_clk_i);
      if (core_clk_en_o === 1'b1) c++;
    end
  endtask
  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Free-running clock and a cycle ceiling against hangs.
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      final_report();
    end
  end
  // Main sequence of register accesses.
  initial begin
    {rst_n_i, ce_i, arb_active_i, err_src_i, gp_irq_i, prof_done_i} = {1'b0, 1'b1, 21'h000000};
    repeat (3) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    dspsc_host_model_i.wr(24'h000004, 32'hffffffff);
    foreach (addrs[i]) rchk("reset value", addrs[i], 32'h0);
    chk("core held", 1'b0, core_reset_n_o);
    cnt(k);
    chk("idle clock", 0, k);
    arb_active_i = 8'h01;
    cnt(k);
    chk("arbiter clock", 1, k > 0);
    arb_active_i = 8'h00;
    for (int b = 0; b < 7; b++) dspsc_host_model_i.wr(`DSPSC_PMEM_FIRST_ADDR + 4 * b, b == 1 ? 32'h0 : 32'h3);
    repeat (3) @(negedge ref_clk_i);
    chk("even chain", 7'h01, pmem_even_avail_o);
    dspsc_host_model_i.wr(`DSPSC_PMEM_FIRST_ADDR + 4, 32'h2);
    dspsc_host_model_i.wr(`DSPSC_PMEM_PWR_ADDR, 32'h1);
    repeat (3) @(negedge ref_clk_i);
    chk("bank bits", {7'h7f, 7'h01}, {pmem_even_avail_o, pmem_odd_avail_o});
    chk("power", 2'b01, {pmem_even_active_o, pmem_odd_active_o});
    rchk("bank 2", `DSPSC_PMEM_FIRST_ADDR + 8, 32'h3);
    dspsc_host_model_i.wr(`DSPSC_CLK_REQ_ADDR, 32'h0200);
    rchk("request", `DSPSC_CLK_REQ_ADDR, 32'h0200);
    rchk("actual off", `DSPSC_CLK_ACT_ADDR, 32'h0);
    dspsc_host_model_i.wr(`DSPSC_CORE_CTRL_ADDR, 32'h1);
    repeat (5) @(negedge ref_clk_i);
    chk("core run", 1'b1, core_reset_n_o);
    cnt(k);
    chk("core clock", 1, k > 0);
    foreach (reqs[i]) begin
      dspsc_host_model_i.wr(`DSPSC_CLK_REQ_ADDR, reqs[i]);
      repeat (4) @(negedge ref_clk_i);
      rchk("actual", `DSPSC_CLK_ACT_ADDR, fexp(reqs[i]));
      chk("clock low", 1'b0, clk_low_event_o);
    end
    // An over-range request is capped at the ceiling and raises the low-clock event.
    dspsc_host_model_i.wr(`DSPSC_CLK_REQ_ADDR, 32'h0600);
    repeat (4) @(negedge ref_clk_i);
    rchk("actual capped", `DSPSC_CLK_ACT_ADDR, {16'h0000, `DSPSC_MAX_FREQ});
    chk("clock low set", 1'b1, clk_low_event_o);
    dspsc_host_model_i.wr(`DSPSC_CORE_CTRL_ADDR, 32'h201);
    k = 0;
    repeat (5) begin
      @(negedge ref_clk_i);
      if (core_reset_n_o === 1'b0) k = 1;
    end
    chk("restart", 1, k);
    chk("running again", 1'b1, core_reset_n_o);
    rchk("core control", `DSPSC_CORE_CTRL_ADDR, 32'h1);
    {err_src_i, gp_irq_i, prof_done_i} = 13'h1f69;
    @(negedge ref_clk_i);
    chk("event lines", 13'h1f69, {err_irq_o, gp_irq_o, prof_irq_o});
    chk("nmi", 1'b1, nmi_o);
    {err_src_i, gp_irq_i, prof_done_i} = 13'h0000;
    dspsc_host_model_i.wr(`DSPSC_ARB_MASK_ADDR, 32'ha5);
    rchk("mask", `DSPSC_ARB_MASK_ADDR, 32'ha5);
    dspsc_host_model_i.wr(`DSPSC_ARB_CTRL_ADDR, 32'h1);
    cap();
    chk("resync", 10'h0a5, pv);
    rchk("resync reads", `DSPSC_ARB_CTRL_ADDR, 32'h0);
    dspsc_host_model_i.wr(`DSPSC_CORE_CTRL_ADDR, 32'h0);
    repeat (4) @(negedge ref_clk_i);
    chk("core stopped", 1'b0, core_reset_n_o);
    dspsc_host_model_i.wr(`DSPSC_SOFT_RST_ADDR, 32'h1);
    cap();
    chk("soft reset", 10'h3ff, pv);
    rchk("request cleared", `DSPSC_CLK_REQ_ADDR, 32'h0);
    rchk("bank kept", `DSPSC_PMEM_FIRST_ADDR + 8, 32'h3);
    rchk("power kept", `DSPSC_PMEM_PWR_ADDR, 32'h1);
    chk("odd active kept", 1'b1, pmem_odd_active_o);
    // A write while the clock enable is low must be ignored.
    ce_i = 1'b0;
    dspsc_host_model_i.wr(`DSPSC_PMEM_PWR_ADDR, 32'h3);
    ce_i = 1'b1;
    rchk("power frozen", `DSPSC_PMEM_PWR_ADDR, 32'h1);
    dspsc_host_model_i.wr(`DSPSC_PMEM_PWR_ADDR, 32'h3);
    repeat (3) @(negedge ref_clk_i);
    chk("both active", 2'b11, {pmem_even_active_o, pmem_odd_active_o});
    // A pin reset in mid-run disables every bank, so memory contents are not kept.
    rst_n_i = 1'b0;
    @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    rchk("bank cleared", `DSPSC_PMEM_FIRST_ADDR + 8, 32'h0);
    chk("odd active off", 1'b0, pmem_odd_active_o);
    final_report();
  end
endmodule
